// File: rtl/hdc_pkg.sv
// constants and types shared by the halting debug control block
package hdc_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_STC = 8'h00;
    localparam logic [7:0] OFS_DTR = 8'h04;
    localparam logic [7:0] OFS_EVCFG = 8'h08;
    // debug status and control field positions
    localparam int STC_HALTED = 0;
    localparam int STC_RESTARTED = 1;
    localparam int STC_NOPWRDWN = 9;
    localparam int STC_HALT_MODE = 14;
    localparam int STC_MON_MODE = 15;
    localparam int STC_WFULL = 29;
    localparam int STC_RFULL = 30;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic RST_RESTARTED = 1'b1;
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    // scan port instruction codes
    localparam logic [4:0] IR_RESTART = 5'h04;
    localparam logic [4:0] IR_HALT = 5'h08;
    localparam logic [4:0] IR_STC = 5'h0d;
    localparam logic [4:0] IR_DTR = 5'h0e;
    localparam logic [4:0] IR_EVCFG = 5'h0f;
    localparam logic [4:0] IR_ITR = 5'h1d;
    localparam logic [4:0] IR_BYPASS = 5'h1f;
    // scan port state machine
    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } hdc_tap_t;
endpackage

// File: rtl/hdc_top.sv
// halting debug control: scan port, halt and restart handshakes, status and apb view
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - halting mode bit 14, scan writable only
// - six events stop the core
// - hardware events halt only when debug allowed
// - scanned instructions forwarded to core while halted
// - data transfer register between core and probe
// - performance counters stop while halted
// - bit 1 set when restart completes
// - event config reachable by scan always
// - acknowledge shows halted debug state
// - permit low: bits 15:14 zero, no halt
// - external halt request forces halt
// - powerdown block output follows bit 9
// - three stage test clock synchronizer, returned
// - test clock synchronizer flops cleared by scan reset
// - halt command acts passing run test idle
// - halt commands work without halting mode
// - halted bit set on halt entry
// - halted: hold pc, mask irq, fetch itr
// - restart takes effect entering run test idle
// - code 00100 decodes as restart
// - code 01000 decodes as halt
module hdc_top
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // debug scan port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic scan_port_reset_n_i,
    output logic tdo_o,
    output logic returned_test_clock_o,
    // external debug signals
    input wire logic debug_permit_in_i,
    input wire logic ext_halt_request_in_i,
    output logic debug_ack_out_o,
    output logic powerdown_block_out_o,
    // core side events
    input wire logic brk_hit_i,
    input wire logic wpt_hit_i,
    input wire logic soft_breakpoint_instr_i,
    input wire logic vector_catch_i,
    input wire logic debug_allowed_i,
    // core side control
    output logic core_halted_o,
    output logic counter_stop_o,
    output logic [31:0] itr_instr_o,
    output logic itr_valid_o,
    output logic [31:0] evcfg_o
);
    import hdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // test clock synchronizer and pin synchronizers

    logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
    logic tms_s1_reg, tms_s2_reg, tdi_s1_reg, tdi_s2_reg;
    logic perm_s1_reg, perm_s2_reg, ext_s1_reg, ext_s2_reg;

    // a trst pulse must clear all three stages at once, so no clock is needed
    always_ff @(posedge clk_i or negedge scan_port_reset_n_i)
    begin
        if (!scan_port_reset_n_i)
        begin
            tck_s1_reg <= 1'b0;
            tck_s2_reg <= 1'b0;
            tck_s3_reg <= 1'b0;
        end
        else
        begin
            tck_s1_reg <= tck_i;
            tck_s2_reg <= tck_s1_reg;
            tck_s3_reg <= tck_s2_reg;
        end
    end

    // tms and tdi take the same two stages as the clock edge detector, so they stay aligned
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tms_s1_reg <= 1'b1;
            tms_s2_reg <= 1'b1;
            tdi_s1_reg <= 1'b0;
            tdi_s2_reg <= 1'b0;
            perm_s1_reg <= 1'b0;
            perm_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end
        else
        begin
            tms_s1_reg <= tms_i;
            tms_s2_reg <= tms_s1_reg;
            tdi_s1_reg <= tdi_i;
            tdi_s2_reg <= tdi_s1_reg;
            perm_s1_reg <= debug_permit_in_i;
            perm_s2_reg <= perm_s1_reg;
            ext_s1_reg <= ext_halt_request_in_i;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // the probe advances once this edge comes back, or raises its fault flag after 16 cycles, so no edge is missed unnoticed
    assign returned_test_clock_o = tck_s3_reg;

    wire tck_rise = tck_s2_reg & ~tck_s3_reg;
    wire tck_fall = ~tck_s2_reg & tck_s3_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // scan port state machine

    function automatic hdc_tap_t tap_next(input hdc_tap_t s, input logic tms);
        case (s)
            TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction

    hdc_tap_t tap_reg;
    logic [4:0] ir_reg, ir_sh_reg;
    logic [31:0] dr_sh_reg;
    logic byp_reg, tdo_reg;

    hdc_tap_t tap_next_w;
    assign tap_next_w = tap_next(tap_reg, tms_s2_reg);

    wire rti_entry = tck_rise & (tap_next_w == TAP_RTI) & (tap_reg != TAP_RTI);
    wire cmd_restart = (ir_reg == IR_RESTART);
    wire cmd_halt = (ir_reg == IR_HALT);
    wire sel_stc = (ir_reg == IR_STC);
    wire sel_dtr = (ir_reg == IR_DTR);
    wire sel_evcfg = (ir_reg == IR_EVCFG);
    wire sel_itr = (ir_reg == IR_ITR);
    wire sel_long = sel_stc | sel_dtr | sel_evcfg | sel_itr;
    wire upd_dr = tck_rise & (tap_reg == TAP_UPD_DR);
    wire cap_dr = tck_rise & (tap_reg == TAP_CAP_DR);
    wire upd_dtr = upd_dr & sel_dtr;
    wire cap_dtr = cap_dr & sel_dtr;
    wire upd_stc = upd_dr & sel_stc;
    wire upd_itr = upd_dr & sel_itr;

    ////////////////////////////////////////////////////////////////////////////////
    // debug state and status registers

    logic halted_reg, restarted_reg, halt_mode_reg, mon_mode_reg, nopwrdwn_reg, rfull_reg, wfull_reg;
    logic [31:0] rdtr_reg, wdtr_reg, evcfg_reg, itr_reg;
    logic itr_valid_reg;

    // mode bits read as zero while debug is not permitted
    function automatic logic [31:0] stc_view(input logic permit, input logic hm, input logic mm,
                                             input logic pd, input logic hl, input logic rs,
                                             input logic rf, input logic wf);
        logic [31:0] v;
        v = RST_WORD;
        v[STC_HALTED] = hl;
        v[STC_RESTARTED] = rs;
        v[STC_NOPWRDWN] = pd;
        v[STC_HALT_MODE] = hm & permit;
        v[STC_MON_MODE] = mm & permit;
        v[STC_WFULL] = wf;
        v[STC_RFULL] = rf;
        stc_view = v;
    endfunction

    wire [31:0] stc_w = stc_view(perm_s2_reg, halt_mode_reg, mon_mode_reg, nopwrdwn_reg,
                                 halted_reg, restarted_reg, rfull_reg, wfull_reg);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tap_reg <= TAP_TLR;
            ir_reg <= IR_BYPASS;
            ir_sh_reg <= IR_CAPTURE;
            dr_sh_reg <= RST_WORD;
            byp_reg <= 1'b0;
            tdo_reg <= 1'b0;
        end
        else if (tck_rise)
        begin
            tap_reg <= tap_next_w;
            case (tap_reg)
                TAP_TLR: ir_reg <= IR_BYPASS;
                TAP_CAP_IR: ir_sh_reg <= IR_CAPTURE;
                TAP_SH_IR: ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[4:1]};
                TAP_CAP_DR:
                begin
                    byp_reg <= 1'b0;
                    dr_sh_reg <= sel_stc ? stc_w : sel_dtr ? wdtr_reg : sel_evcfg ? evcfg_reg : itr_reg;
                end
                TAP_SH_DR:
                begin
                    byp_reg <= tdi_s2_reg;
                    dr_sh_reg <= {tdi_s2_reg, dr_sh_reg[31:1]};
                end
                default: byp_reg <= byp_reg;
            endcase
        end
        else if (tck_fall)
        begin
            tdo_reg <= (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : sel_long ? dr_sh_reg[0] : byp_reg;
            // new instruction settles on the falling edge, so the rise into run test idle already acts on it
            if (tap_reg == TAP_UPD_IR)
                ir_reg <= ir_sh_reg;
        end
    end

    assign tdo_o = tdo_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // halt and restart

    wire hw_event = brk_hit_i | wpt_hit_i | soft_breakpoint_instr_i | vector_catch_i;
    wire hw_halt = halt_mode_reg & hw_event;
    // scanned halt and external request do not need the mode bit, so a core can be stopped after reset
    wire cmd_halt_go = rti_entry & cmd_halt;
    wire halt_go = ~halted_reg & perm_s2_reg & debug_allowed_i & (hw_halt | ext_s2_reg | cmd_halt_go);
    wire restart_go = halted_reg & rti_entry & cmd_restart;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            halted_reg <= 1'b0;
            restarted_reg <= RST_RESTARTED;
        end
        else if (halt_go)
        begin
            halted_reg <= 1'b1;
            restarted_reg <= 1'b0;
        end
        else if (restart_go)
        begin
            halted_reg <= 1'b0;
            restarted_reg <= 1'b1;
        end
    end

    assign debug_ack_out_o = halted_reg;
    assign core_halted_o = halted_reg;
    assign counter_stop_o = halted_reg;
    assign powerdown_block_out_o = nopwrdwn_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave

    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;

    wire apb_setup = psel_i & ~penable_i;
    wire apb_fire = psel_i & penable_i & pready_reg;
    wire hit_stc = (paddr_i == OFS_STC);
    wire hit_dtr = (paddr_i == OFS_DTR);
    wire hit_evcfg = (paddr_i == OFS_EVCFG);
    wire apb_hit = hit_stc | hit_dtr | hit_evcfg;
    wire apb_rd_dtr = apb_fire & ~pwrite_i & hit_dtr;
    wire apb_wr_dtr = apb_fire & pwrite_i & hit_dtr;
    wire [31:0] rd_mux = hit_stc ? stc_w : hit_dtr ? rdtr_reg : hit_evcfg ? evcfg_reg : RST_WORD;

    // no wait state: pready and prdata come straight from flops loaded in the setup cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RST_WORD;
        end
        else
        begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & ~apb_hit;
            prdata_reg <= (apb_setup & ~pwrite_i) ? rd_mux : RST_WORD;
        end
    end

    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign prdata_o = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // scan written registers, data transfer and instruction transfer

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            halt_mode_reg <= 1'b0;
            mon_mode_reg <= 1'b0;
            nopwrdwn_reg <= 1'b0;
            evcfg_reg <= RST_WORD;
            itr_reg <= RST_WORD;
            itr_valid_reg <= 1'b0;
            rdtr_reg <= RST_WORD;
            wdtr_reg <= RST_WORD;
            rfull_reg <= 1'b0;
            wfull_reg <= 1'b0;
        end
        else
        begin
            // apb writes never reach the mode bits
            if (upd_stc)
            begin
                halt_mode_reg <= dr_sh_reg[STC_HALT_MODE];
                mon_mode_reg <= dr_sh_reg[STC_MON_MODE];
                nopwrdwn_reg <= dr_sh_reg[STC_NOPWRDWN];
            end
            if (upd_dr & sel_evcfg)
            begin
                evcfg_reg <= dr_sh_reg;
            end
            // instructions scanned while running are dropped, the core only fetches from here when halted
            itr_valid_reg <= upd_itr & halted_reg;
            if (upd_itr)
            begin
                itr_reg <= dr_sh_reg;
            end
            if (upd_dtr)
            begin
                rdtr_reg <= dr_sh_reg;
            end
            if (apb_wr_dtr)
            begin
                wdtr_reg <= pwdata_i;
            end
            // set wins over clear on both full flags
            rfull_reg <= upd_dtr | (rfull_reg & ~apb_rd_dtr);
            wfull_reg <= apb_wr_dtr | (wfull_reg & ~cap_dtr);
        end
    end

    assign evcfg_o = evcfg_reg;
    assign itr_instr_o = itr_reg;
    assign itr_valid_o = itr_valid_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_NO_HALT_UNPERMITTED: assert property (!perm_s2_reg && !halted_reg |=> !halted_reg)
        else $error("halt entered without debug permit");
    AST_MODE_BITS_MASKED: assert property (!perm_s2_reg |-> stc_w[15:14] == 2'b00)
        else $error("mode bits visible without debug permit");
    AST_EXT_HALT: assert property (perm_s2_reg && debug_allowed_i && ext_s2_reg && !halted_reg
                                   |=> halted_reg && debug_ack_out_o && !restarted_reg)
        else $error("external halt request did not halt");
    AST_HW_NEEDS_MODE: assert property (hw_event && !halt_mode_reg && !ext_s2_reg && !rti_entry && !halted_reg
                                        |=> !halted_reg)
        else $error("hardware event halted without halting mode");
    AST_RESTART_AT_RTI: assert property ($fell(halted_reg) |-> $past(rti_entry) && $past(ir_reg) == IR_RESTART)
        else $error("restart outside run test idle entry");
    AST_RESTARTED_SET: assert property ($fell(halted_reg) |-> restarted_reg && !debug_ack_out_o)
        else $error("restarted bit not set after restart");
    AST_HALT_CMD: assert property (cmd_halt_go && perm_s2_reg && debug_allowed_i && !halted_reg
                                   |=> halted_reg ##0 stc_w[STC_HALTED])
        else $error("scanned halt did not take effect");
    AST_ITR_HALTED_ONLY: assert property (itr_valid_o |-> halted_reg && $past(upd_itr))
        else $error("instruction issued while running");
    AST_RFULL_SET: assert property (upd_dtr |=> rfull_reg && rdtr_reg == $past(dr_sh_reg))
        else $error("scan data word not latched");
    AST_RET_CLK_DELAY: assert property (scan_port_reset_n_i && $past(scan_port_reset_n_i, 3)
                                     |-> returned_test_clock_o == $past(tck_i, 3))
        else $error("returned clock not three stages behind");
endmodule

// File: bench/hdc_probe.sv
// behavioural debug probe that clocks the scan port through the returned clock handshake
`timescale 1ns/100ps
module hdc_probe
(
    // clock
    input wire logic clk_i,
    // scan port pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic ret_clk_i,
    // status
    output logic fault_o
);
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        fault_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // bounded wait: a lost returned edge raises the fault flag instead of hanging
    task automatic wait_ret_clk(input logic v);
        int n;
        n = 0;
        while (ret_clk_i !== v && n < 16)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 16)
            fault_o <= 1'b1;
    endtask
    // one test clock period; tdo is taken just before the rising edge
    task automatic tbit(input logic m, input logic d, output logic o);
        @(posedge clk_i);
        tms_o <= m;
        tdi_o <= d;
        wait_ret_clk(1'b0);
        @(posedge clk_i);
        o = tdo_i;
        tck_o <= 1'b1;
        wait_ret_clk(1'b1);
        tck_o <= 1'b0;
    endtask
    // tdi toggles when no bit is being shifted, so a stale level is never mistaken for data
    task automatic tm(input logic m);
        logic o;
        tbit(m, ~tdi_o, o);
    endtask
    task automatic to_rti();
        repeat (5) tm(1'b1);
        tm(1'b0);
    endtask
    task automatic ir(input logic [4:0] code);
        logic o;
        tm(1'b1);
        tm(1'b1);
        tm(1'b0);
        tm(1'b0);
        for (int i = 0; i < 5; i++)
            tbit(i == 4, code[i], o);
        tm(1'b1);
        tm(1'b0);
    endtask
    task automatic dr(input logic [4:0] code, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        ir(code);
        tm(1'b1);
        tm(1'b0);
        tm(1'b0);
        for (int i = 0; i < 32; i++)
        begin
            tbit(i == 31, din[i], o);
            dout[i] = o;
        end
        tm(1'b1);
        tm(1'b0);
    endtask
    task automatic set_tck(input logic v);
        @(posedge clk_i);
        tck_o <= v;
    endtask
endmodule

// File: bench/test_halting_debug_control.sv
// self-checking bench for the halting debug control block
`timescale 1ns/100ps
module test_halting_debug_control;
    import hdc_pkg::*;
    typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} hdc_note_t;
    logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, itr_instr_o, evcfg_o, w, v, got;
    logic tck, tms, tdi, tdo, ret_clk, scan_rst_n, permit, ext_halt, allowed, fault;
    logic ack, pd, halted, cstop, itr_valid;
    logic [3:0] ev;
    hdc_note_t notes[$];
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    hdc_top dut
    (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .scan_port_reset_n_i(scan_rst_n), .tdo_o(tdo),
        .returned_test_clock_o(ret_clk), .debug_permit_in_i(permit), .ext_halt_request_in_i(ext_halt),
        .debug_ack_out_o(ack), .powerdown_block_out_o(pd), .brk_hit_i(ev[0]), .wpt_hit_i(ev[1]),
        .soft_breakpoint_instr_i(ev[2]), .vector_catch_i(ev[3]), .debug_allowed_i(allowed),
        .core_halted_o(halted), .counter_stop_o(cstop), .itr_instr_o(itr_instr_o), .itr_valid_o(itr_valid),
        .evcfg_o(evcfg_o)
    );
    hdc_probe probe (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .ret_clk_i(ret_clk),
                     .fault_o(fault));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    // an unexpected result finds the queue empty and counts as a mismatch
    task automatic pop(input logic e, input logic [31:0] d);
        hdc_note_t n;
        if (notes.size() == 0)
        begin
            compares++;
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, d, 32'h0);
        end
        else
        begin
            n = notes.pop_front();
            chk(d & n.mask, n.data & n.mask);
            chk({31'h0, e}, {31'h0, n.err});
        end
    endtask
    function automatic logic [31:0] stc(input logic h, input logic r, input logic p, input logic m);
        logic [31:0] d;
        d = 32'h0;
        d[STC_HALTED] = h;
        d[STC_RESTARTED] = r;
        d[STC_NOPWRDWN] = p;
        d[STC_HALT_MODE] = m;
        return d;
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // pready ends this wait; only the bench timeout bounds it
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input logic err);
        notes.push_back({err, mask, exp});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic fire(input int k);
        @(posedge clk_i);
        ev <= 4'h1 << k;
        @(posedge clk_i);
        ev <= 4'h0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic restart(input logic [31:0] exp);
        probe.ir(IR_RESTART);
        repeat (3) @(posedge clk_i);
        chk({30'h0, ack, halted}, 32'h0);
        rd(OFS_STC, exp, 32'hffff_ffff, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
            pop(pslverr_o, prdata_o);
        if (itr_valid === 1'b1)
            pop(1'b0, itr_instr_o);
    end
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        {psel_i, penable_i, pwrite_i, nrst_i, scan_rst_n, ext_halt, permit} = 7'h00;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        ev = 4'h0;
        allowed = 1'b1;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        scan_rst_n <= 1'b1;
        void'($urandom(28));
        probe.to_rti();
        rd(OFS_STC, stc(1'b0, 1'b1, 1'b0, 1'b0), 32'hffff_ffff, 1'b0);
        rd(8'h0c, 32'h0, 32'hffff_ffff, 1'b1);
        apb(1'b1, OFS_STC, 32'hffff_ffff);
        rd(OFS_STC, stc(1'b0, 1'b1, 1'b0, 1'b0), 32'hffff_ffff, 1'b0);
        // permit low: mode bit hidden and no halt from either source
        probe.dr(IR_STC, 32'h0000_4200, got);
        rd(OFS_STC, stc(1'b0, 1'b1, 1'b1, 1'b0), 32'hffff_ffff, 1'b0);
        chk({31'h0, pd}, 32'h1);
        ext_halt <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({31'h0, ack}, 32'h0);
        ext_halt <= 1'b0;
        probe.ir(IR_HALT);
        repeat (3) @(posedge clk_i);
        chk({31'h0, ack}, 32'h0);
        permit <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(OFS_STC, stc(1'b0, 1'b1, 1'b1, 1'b1), 32'hffff_ffff, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            allowed <= 1'b0;
            fire(k);
            chk({29'h0, ack, halted, cstop}, 32'h0);
            allowed <= 1'b1;
            fire(k);
            chk({29'h0, ack, halted, cstop}, 32'h7);
            rd(OFS_STC, 32'h1, 32'h1, 1'b0);
            restart(stc(1'b0, 1'b1, 1'b1, 1'b1));
        end
        // halting mode off: only the request and the scanned halt still stop the core
        probe.dr(IR_STC, 32'h0, got);
        chk({31'h0, pd}, 32'h0);
        ext_halt <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({30'h0, ack, halted}, 32'h3);
        ext_halt <= 1'b0;
        restart(stc(1'b0, 1'b1, 1'b0, 1'b0));
        probe.ir(IR_HALT);
        repeat (3) @(posedge clk_i);
        chk({30'h0, ack, halted}, 32'h3);
        w = $urandom();
        notes.push_back({1'b0, 32'hffff_ffff, w});
        probe.dr(IR_ITR, w, got);
        w = $urandom();
        probe.dr(IR_EVCFG, w, got);
        chk(evcfg_o, w);
        restart(stc(1'b0, 1'b1, 1'b0, 1'b0));
        probe.dr(IR_ITR, ~w, got);
        w = $urandom();
        probe.dr(IR_EVCFG, w, got);
        rd(OFS_EVCFG, w, 32'hffff_ffff, 1'b0);
        apb(1'b1, OFS_EVCFG, ~w);
        rd(OFS_EVCFG, w, 32'hffff_ffff, 1'b0);
        // data words in both directions with their full flags
        w = $urandom();
        v = $urandom();
        apb(1'b1, OFS_DTR, w);
        rd(OFS_STC, 32'h2000_0000, 32'h6000_0000, 1'b0);
        probe.dr(IR_DTR, v, got);
        chk(got, w);
        rd(OFS_STC, 32'h4000_0000, 32'h6000_0000, 1'b0);
        rd(OFS_DTR, v, 32'hffff_ffff, 1'b0);
        rd(OFS_STC, 32'h0, 32'h4000_0000, 1'b0);
        // returned clock lags three flops and is cleared by the scan reset
        probe.set_tck(1'b1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, ret_clk}, 32'h0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, ret_clk}, 32'h1);
        scan_rst_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({31'h0, ret_clk}, 32'h0);
        probe.set_tck(1'b0);
        repeat (4) @(posedge clk_i);
        scan_rst_n <= 1'b1;
        chk({31'h0, fault}, 32'h0);
        repeat (4) @(posedge clk_i);
        chk(32'(notes.size()), 32'h0);
        complete_run();
    end
endmodule
